// ---- rtl/csgs_regs.vh ----
// Register indices, field positions, reset values and timing counts
`ifndef CSGS_REGS_VH
`define CSGS_REGS_VH

// Register indices; byte address is four times the index
`define CSGS_IDX_GEAR        12'h0fcf
`define CSGS_IDX_SYS1        12'h0fdc
`define CSGS_IDX_SYS2        12'h0fdd
`define CSGS_IDX_PORT0_FN    12'h0fc0
`define CSGS_IDX_STATUS      12'h0fc1
`define CSGS_ADR_W           16

// Gear register fields
`define CSGS_GEAR_LSB        0
`define CSGS_GEAR_MSB        1
`define CSGS_GEAR_RST        2'h0
`define CSGS_GEAR_DIV4       2'h0
`define CSGS_GEAR_DIV2       2'h1
`define CSGS_GEAR_DIV1       2'h2

// System control one fields
`define CSGS_SYS1_REFSEL     3

// System control two fields
`define CSGS_SYS2_INT_EN     7
`define CSGS_SYS2_XH_EN      6
`define CSGS_SYS2_XL_EN      5
`define CSGS_SYS2_SYSCK      4
`define CSGS_SYS2_RST        4'h8

// Port 0 function control fields
`define CSGS_PFN_HIGH        0
`define CSGS_PFN_LOW         2

// Status fields
`define CSGS_ST_BUSY         0
`define CSGS_ST_REF_EXT      1
`define CSGS_ST_CLK_RST      2

// Switch settles after this many falling edges of the new clock
`define CSGS_SW_NEW_EDGES    2'h2

// Switch FSM one-hot states
`define CSGS_SW_RUN          3'h1
`define CSGS_SW_DRAIN        3'h2
`define CSGS_SW_ARM          3'h4

`endif

// ---- rtl/csgs_clk_div.v ----
// Divides a sampled clock level by 4, 2 or 1 into a registered level
`include "csgs_regs.vh"

module csgs_clk_div (
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire       src_lvl,
   input  wire [1:0] div_sel,
   output reg        div_q
);

   reg       src_prev_q;
   reg       phase_q;
   wire      src_rise;

   assign src_rise = src_lvl & ~src_prev_q;

   // Edge history and divided level; reserved code runs as divide by 4
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_q <= 1'b0;
         phase_q    <= 1'b0;
         div_q      <= 1'b0;
      end else begin
         src_prev_q <= src_lvl;
         case (div_sel)
            `CSGS_GEAR_DIV1: begin
               div_q <= src_lvl;
            end
            `CSGS_GEAR_DIV2: begin
               if (src_rise) begin
                  div_q <= ~div_q;
               end
            end
            default: begin
               if (src_rise) begin
                  phase_q <= ~phase_q;
                  if (phase_q) begin
                     div_q <= ~div_q;
                  end
               end
            end
         endcase
      end
   end

endmodule

// ---- rtl/csgs_ref_switch.v ----
// Glitch-free change of the high reference clock between two oscillators
`include "csgs_regs.vh"

module csgs_ref_switch (
   input  wire core_clk,
   input  wire rst_n,
   input  wire sel_ext,
   input  wire int_lvl,
   input  wire ext_lvl,
   output reg  ref_q,
   output reg  busy_q,
   output reg  cur_ext_q
);

   reg  [2:0] state_q;
   reg  [1:0] fall_cnt_q;
   reg        new_prev_q;
   wire       old_lvl;
   wire       new_lvl;
   wire       new_fall;

   assign old_lvl  = cur_ext_q ? ext_lvl : int_lvl;
   assign new_lvl  = cur_ext_q ? int_lvl : ext_lvl;
   assign new_fall = new_prev_q & ~new_lvl;

   // Old clock is let finish its high phase, output parks low, then
   // the new clock is picked up on a low phase so no runt pulse escapes
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= `CSGS_SW_RUN;
         fall_cnt_q <= 2'h0;
         new_prev_q <= 1'b0;
         ref_q      <= 1'b0;
         busy_q     <= 1'b0;
         cur_ext_q  <= 1'b0;
      end else begin
         new_prev_q <= new_lvl;
         case (state_q)
            `CSGS_SW_RUN: begin
               ref_q <= old_lvl;
               if (sel_ext != cur_ext_q) begin
                  state_q <= `CSGS_SW_DRAIN;
                  busy_q  <= 1'b1;
               end
            end
            `CSGS_SW_DRAIN: begin
               ref_q <= old_lvl;
               if (!old_lvl) begin
                  state_q    <= `CSGS_SW_ARM;
                  fall_cnt_q <= 2'h0;
               end
            end
            `CSGS_SW_ARM: begin
               ref_q <= 1'b0;
               if (new_fall) begin
                  fall_cnt_q <= fall_cnt_q + 2'h1;
                  if (fall_cnt_q + 2'h1 == `CSGS_SW_NEW_EDGES) begin
                     cur_ext_q <= ~cur_ext_q;
                     state_q   <= `CSGS_SW_RUN;
                     busy_q    <= 1'b0;
                  end
               end
            end
            default: begin
               state_q <= `CSGS_SW_RUN;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ---- rtl/csgs_top.v ----
// Clock source control: oscillator enables, reference switch, gear, reset check
//
// Local design decision: the Wishbone register port.
`include "csgs_regs.vh"

module csgs_top (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [15:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        int_high_clock,
   input  wire        external_high_clock,
   input  wire        external_low_clock,
   input  wire        stop_mode,
   output reg         int_osc_en_q,
   output reg         high_osc_en_q,
   output reg         low_osc_en_q,
   output reg         high_osc_pin_q,
   output reg         low_osc_pin_q,
   output reg         sys_clk_q,
   output reg         warmup_start_q,
   output reg         sys_clk_rst_q
);

   // Software visible state
   reg  [1:0]  gear_sel_q;
   reg         ref_sel_q;
   reg         int_en_q;
   reg         xh_en_q;
   reg         xl_en_q;
   reg         sysck_q;
   reg         pfn_high_q;
   reg         pfn_low_q;

   // Bus decode
   wire        bus_req;
   wire        wr_en;
   wire [11:0] idx;
   wire        adr_ok;
   reg  [31:0] rd_d;

   // Clock path
   wire        high_ref;
   wire        sw_busy;
   wire        ref_ext;
   wire        gear_clk;
   wire        low_div4;

   // Check and warm-up start terms
   reg         bad_d;
   wire        old_src_off;
   wire        sys2_wr;
   wire        xh_rise_wr;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];
   assign idx     = wb_adr_i[13:2];
   assign adr_ok  = (wb_adr_i[15:14] == 2'h0) && (wb_adr_i[1:0] == 2'h0);

   // Write to system control two, used by the warm-up start only
   assign sys2_wr     = wr_en && adr_ok && (idx == `CSGS_IDX_SYS2);
   // a start needs the stored enable low before the write
   assign xh_rise_wr  = sys2_wr && wb_dat_i[`CSGS_SYS2_XH_EN] && !xh_en_q;
   // enable of the source still feeding the reference
   assign old_src_off = ref_ext ? !xh_en_q : !int_en_q;

   // Single-cycle answer: ack one edge after the request is seen
   // A request seen while ack is high is not taken again, so ack is one pulse
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Register writes; reset values are the hardware's own start-up choice
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gear_sel_q <= `CSGS_GEAR_RST;
         ref_sel_q  <= 1'b0;
         int_en_q   <= 1'b1;
         xh_en_q    <= 1'b0;
         xl_en_q    <= 1'b0;
         sysck_q    <= 1'b0;
         pfn_high_q <= 1'b0;
         pfn_low_q  <= 1'b0;
      end else if (wr_en && adr_ok) begin
         case (idx)
            `CSGS_IDX_GEAR: begin
               gear_sel_q <= wb_dat_i[`CSGS_GEAR_MSB:`CSGS_GEAR_LSB];
            end
            `CSGS_IDX_SYS1: begin
               if (!sysck_q) begin
                  ref_sel_q <= wb_dat_i[`CSGS_SYS1_REFSEL];
               end
            end
            `CSGS_IDX_SYS2: begin
               int_en_q <= wb_dat_i[`CSGS_SYS2_INT_EN];
               xh_en_q  <= wb_dat_i[`CSGS_SYS2_XH_EN];
               xl_en_q  <= wb_dat_i[`CSGS_SYS2_XL_EN];
               sysck_q  <= wb_dat_i[`CSGS_SYS2_SYSCK];
            end
            `CSGS_IDX_PORT0_FN: begin
               // Crystal pin use; the check flags the external high enable set first
               pfn_high_q <= wb_dat_i[`CSGS_PFN_HIGH];
               pfn_low_q  <= wb_dat_i[`CSGS_PFN_LOW];
            end
            default: begin
               gear_sel_q <= gear_sel_q;
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero but are still acknowledged
   always @* begin
      rd_d = 32'h0000_0000;
      if (adr_ok) begin
         case (idx)
            `CSGS_IDX_GEAR: begin
               rd_d[`CSGS_GEAR_MSB:`CSGS_GEAR_LSB] = gear_sel_q;
            end
            `CSGS_IDX_SYS1: begin
               rd_d[`CSGS_SYS1_REFSEL] = ref_sel_q;
            end
            `CSGS_IDX_SYS2: begin
               rd_d[`CSGS_SYS2_INT_EN] = int_en_q;
               rd_d[`CSGS_SYS2_XH_EN]  = xh_en_q;
               rd_d[`CSGS_SYS2_XL_EN]  = xl_en_q;
               rd_d[`CSGS_SYS2_SYSCK]  = sysck_q;
            end
            `CSGS_IDX_PORT0_FN: begin
               rd_d[`CSGS_PFN_HIGH] = pfn_high_q;
               rd_d[`CSGS_PFN_LOW]  = pfn_low_q;
            end
            `CSGS_IDX_STATUS: begin
               // Read-only; writes here land in the default branch
               rd_d[`CSGS_ST_BUSY]    = sw_busy;
               rd_d[`CSGS_ST_REF_EXT] = ref_ext;
               rd_d[`CSGS_ST_CLK_RST] = sys_clk_rst_q;
            end
            default: begin
               rd_d = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read data held from the answer edge
   // Kept until the next request so a slow master can still take it
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req) begin
         wb_dat_o <= rd_d;
      end
   end

   // warm-up only on a real 0 to 1 of the external enable
   // Rewriting an already set enable leaves the warm-up alone
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         warmup_start_q <= 1'b0;
      end else begin
         warmup_start_q <= xh_rise_wr;
      end
   end

   // stop mode halts every oscillator and returns pins to ports
   // without touching the software bits so the check does not trip
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_osc_en_q   <= 1'b1;
         high_osc_en_q  <= 1'b0;
         low_osc_en_q   <= 1'b0;
         high_osc_pin_q <= 1'b0;
         low_osc_pin_q  <= 1'b0;
      end else begin
         int_osc_en_q   <= int_en_q & ~stop_mode;
         high_osc_en_q  <= xh_en_q & ~stop_mode;
         low_osc_en_q   <= xl_en_q & ~stop_mode;
         high_osc_pin_q <= pfn_high_q & ~stop_mode;
         low_osc_pin_q  <= pfn_low_q & ~stop_mode;
      end
   end

   // reference source chosen by the select
   // old clock drains low, new one joins on a low phase
   // the pause is bounded by two falling edges of the new clock
   csgs_ref_switch u_ref_switch (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .sel_ext   (ref_sel_q),
      .int_lvl   (int_high_clock),
      .ext_lvl   (external_high_clock),
      .ref_q     (high_ref),
      .busy_q    (sw_busy),
      .cur_ext_q (ref_ext)
   );

   csgs_clk_div u_gear_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .src_lvl  (high_ref),
      .div_sel  (gear_sel_q),
      .div_q    (gear_clk)
   );

   // Low clock divided by four for slow running
   csgs_clk_div u_low_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .src_lvl  (external_low_clock),
      .div_sel  (`CSGS_GEAR_DIV4),
      .div_q    (low_div4)
   );

   // system clock source select
   // Not glitch protected: the low path bypasses the gear entirely
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_clk_q <= 1'b0;
      end else begin
         sys_clk_q <= sysck_q ? low_div4 : gear_clk;
      end
   end

   // Prohibited combinations; the reference actually in use during a
   // switch is the old one, so its enable is what must stay set
   always @* begin
      bad_d = 1'b0;
      if (!int_en_q && !xh_en_q && !xl_en_q) begin
         bad_d = 1'b1;
      end
      if (sysck_q && !xl_en_q) begin
         bad_d = 1'b1;
      end
      if (!sysck_q && !ref_sel_q && !int_en_q) begin
         bad_d = 1'b1;
      end
      if (!sysck_q && ref_sel_q && !xh_en_q) begin
         bad_d = 1'b1;
      end
      // external enabled on plain port pins
      if (xh_en_q && !pfn_high_q) begin
         bad_d = 1'b1;
      end
      // old source stopped before the switch completes
      if (sw_busy && old_src_off) begin
         bad_d = 1'b1;
      end
   end

   // check registered every cycle, reset follows the next edge
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_clk_rst_q <= 1'b0;
      end else begin
         sys_clk_rst_q <= bad_d;
      end
   end

endmodule

// ---- sim/csgs_properties.sv ----
// Port-level checks of the clock source block
module csgs_properties (
   input logic        core_clk,
   input logic        rst_n,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_we_i,
   input logic [15:0] wb_adr_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   input logic        stop_mode,
   input logic        int_osc_en_q,
   input logic        high_osc_en_q,
   input logic        low_osc_en_q,
   input logic        high_osc_pin_q,
   input logic        low_osc_pin_q,
   input logic        warmup_start_q,
   input logic        sys_clk_rst_q
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Bus answer timing and gear read-back upper bits
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_gear_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && wb_adr_i == 16'h3f3c |=> wb_dat_o[31:2] == 30'h0)
      else $error("gear upper bits not zero");
   // Stop gating makes outputs low while the bits stay set
   a_all_off: assert property ($past(!stop_mode) && !int_osc_en_q && !high_osc_en_q
      && !low_osc_en_q |-> sys_clk_rst_q)
      else $error("no reset with all sources off");
   a_pin_bad: assert property ($past(!stop_mode) && high_osc_en_q
      && !high_osc_pin_q |-> sys_clk_rst_q)
      else $error("no reset with crystal pins as ports");
   a_stop_pins: assert property (stop_mode |=> !high_osc_pin_q && !low_osc_pin_q)
      else $error("pins kept in stop");
   a_stop_osc: assert property (stop_mode |=> !int_osc_en_q && !high_osc_en_q
      && !low_osc_en_q)
      else $error("oscillator kept in stop");
   a_warm_pulse: assert property (warmup_start_q |=> !warmup_start_q)
      else $error("warm-up start too long");
   a_warm_cause: assert property (warmup_start_q |-> $past(wb_we_i)
      && $past(wb_adr_i) == 16'h3f74)
      else $error("warm-up start without write");
   c_write: cover property (wb_ack_o && wb_we_i);
   c_warm: cover property ($rose(warmup_start_q));
   c_reset: cover property ($rose(sys_clk_rst_q));
endmodule

// ---- sim/csgs_osc_model.sv ----
// Behavioural oscillators and crystals around the clock source block
module csgs_osc_model (
   input  logic int_en,
   input  logic high_en,
   input  logic high_pin,
   input  logic low_en,
   input  logic low_pin,
   output logic int_clk,
   output logic high_clk,
   output logic low_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   // Stopped sources rest low
   initial begin
      int_clk = 1'b0;
      high_clk = 1'b0;
      low_clk = 1'b0;
   end
   always #40 int_clk = int_en ? ~int_clk : 1'b0;
   always #30 high_clk = (high_en && high_pin) ? ~high_clk : 1'b0;
   always #100 low_clk = (low_en && low_pin) ? ~low_clk : 1'b0;
endmodule

// ---- sim/clock_source_gear_and_switch_test.sv ----
// Self-checking bench for the clock source block
module clock_source_gear_and_switch_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] adr_gear = 16'h3f3c;
   localparam logic [15:0] adr_sys1 = 16'h3f70;
   localparam logic [15:0] adr_sys2 = 16'h3f74;
   localparam logic [15:0] adr_pfn  = 16'h3f00;
   localparam logic [15:0] adr_stat = 16'h3f04;
   logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stop_mode;
   logic [3:0]  wb_sel_i;
   logic [15:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd_q;
   logic        int_high_clock, external_high_clock, external_low_clock, sys_clk_q;
   logic        int_osc_en_q, high_osc_en_q, low_osc_en_q, high_osc_pin_q, low_osc_pin_q;
   logic        warmup_start_q, sys_clk_rst_q;
   int          errors, checked, per;
   int          warm_cnt = 0;
   csgs_top dut_u (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .int_high_clock, .external_high_clock,
      .external_low_clock, .stop_mode, .int_osc_en_q, .high_osc_en_q, .low_osc_en_q,
      .high_osc_pin_q, .low_osc_pin_q, .sys_clk_q, .warmup_start_q, .sys_clk_rst_q);
   csgs_osc_model osc_u (.int_en(int_osc_en_q), .high_en(high_osc_en_q),
      .high_pin(high_osc_pin_q), .low_en(low_osc_en_q), .low_pin(low_osc_pin_q),
      .int_clk(int_high_clock), .high_clk(external_high_clock), .low_clk(external_low_clock));
   // 100 MHz core clock
   always #5 core_clk = ~core_clk;
   // Counts warm-up start pulses
   always @(posedge core_clk)
      if (warmup_start_q === 1'b1)
         warm_cnt <= warm_cnt + 1;
   task automatic end_sim;
      if (errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic cycle; request held until ack is sampled
   task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1) begin
         if (n++ > 20) begin
            errors++;
            end_sim;
         end
         @(posedge core_clk);
      end
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
   endtask
   // Cycles from one system clock rise to the next
   task automatic period(output int c);
      int n;
      n = 0;
      c = 0;
      for (int k = 0; k < 4; k++) begin
         while (sys_clk_q !== k[0] && n < 500) begin
            @(posedge core_clk);
            n++;
            c += (k > 1);
         end
      end
      if (n >= 500) begin
         errors++;
         end_sim;
      end
   endtask
   task automatic t_reset;
      wb(1'b0, adr_gear, 8'h00);
      chk(rd_q, 32'h0);
      wb(1'b0, adr_sys1, 8'h00);
      chk(rd_q, 32'h0);
      wb(1'b0, adr_sys2, 8'h00);
      chk(rd_q, 32'h0000_0080);
      wb(1'b0, 16'h3f08, 8'h00);
      chk(rd_q, 32'h0);
      chk({31'h0, int_osc_en_q}, 32'h1);
   endtask
   task automatic t_gear;
      wb(1'b1, adr_gear, 8'hfe);
      wb(1'b0, adr_gear, 8'h00);
      chk(rd_q, 32'h0000_0002);
      for (int g = 0; g < 3; g++) begin
         wb(1'b1, adr_gear, 8'(g));
         period(per);
         period(per);
         chk(per, 32 >> g);
      end
   endtask
   task automatic t_prohibit;
      logic [7:0] pf [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h01};
      logic [7:0] s2 [7] = '{8'h80, 8'h00, 8'h20, 8'h30, 8'h90, 8'hc0, 8'hc0};
      logic       ex [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 7; i++) begin
         wb(1'b1, adr_pfn, pf[i]);
         wb(1'b1, adr_sys2, s2[i]);
         chk({31'h0, sys_clk_rst_q}, {31'h0, ex[i]});
         if (i == 3) begin
            period(per);
            period(per);
            chk(per, 80);
            wb(1'b1, adr_sys1, 8'h08);
            wb(1'b0, adr_sys1, 8'h00);
            chk(rd_q, 32'h0);
         end
      end
      stop_mode <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk({27'h0, int_osc_en_q, high_osc_en_q, low_osc_en_q, high_osc_pin_q,
         low_osc_pin_q}, 32'h0);
      stop_mode <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic t_switch;
      int w;
      int n;
      wb(1'b1, adr_sys2, 8'h80);
      w = warm_cnt;
      wb(1'b1, adr_sys2, 8'hc0);
      wb(1'b1, adr_sys2, 8'hc0);
      chk(warm_cnt - w, 1);
      wb(1'b1, adr_sys1, 8'h08);
      wb(1'b0, adr_stat, 8'h00);
      chk(rd_q, 32'h0000_0001);
      n = 0;
      do begin
         wb(1'b0, adr_stat, 8'h00);
         n++;
      end while (rd_q !== 32'h0000_0002 && n < 10);
      chk(rd_q, 32'h0000_0002);
      period(per);
      period(per);
      chk(per, 6);
      // wait, then stop the old source
      repeat (2) @(posedge core_clk);
      wb(1'b1, adr_sys2, 8'h40);
      chk({31'h0, sys_clk_rst_q}, 32'h0);
      wb(1'b1, adr_sys2, 8'h80);
      chk({31'h0, sys_clk_rst_q}, 32'h1);
   endtask
   task automatic t_back;
      int n;
      wb(1'b1, adr_sys2, 8'hc0);
      wb(1'b1, adr_sys1, 8'h00);
      // Old source dropped mid-switch
      wb(1'b1, adr_sys2, 8'h80);
      chk({31'h0, sys_clk_rst_q}, 32'h1);
      n = 0;
      while (sys_clk_rst_q !== 1'b0 && n < 40) begin
         @(posedge core_clk);
         n++;
      end
      chk({31'h0, sys_clk_rst_q}, 32'h0);
   endtask
   initial begin
      {core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, stop_mode} = 6'h00;
      wb_sel_i = 4'h1;
      wb_adr_i = 16'h0000;
      wb_dat_i = 32'h0;
      errors = 0;
      checked = 0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_reset;
      t_gear;
      t_prohibit;
      t_switch;
      t_back;
      end_sim;
   end
endmodule
bind csgs_top csgs_properties chk_u (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .stop_mode, .int_osc_en_q, .high_osc_en_q,
   .low_osc_en_q, .high_osc_pin_q, .low_osc_pin_q, .warmup_start_q, .sys_clk_rst_q);
